// [verilog/iwd_map.svh]
// Address, interval limits and timing constants of the port watchdog
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

`define IWD_PORT_ADDR 16'h0443
`define IWD_CODE_MIN 8'h01
`define IWD_CODE_MAX 8'h3e
`define IWD_CLK_HZ 10000000
`define IWD_TICK_S 1
`define IWD_TICK_CYCLES (`IWD_CLK_HZ * `IWD_TICK_S)
`define IWD_RST_PULSE_CYCLES 16

`endif

// [verilog/iwd_pkg.sv]
// Types of the port watchdog
package iwd_pkg;
    typedef enum logic [1:0] {
        IWD_IDLE,
        IWD_RUN,
        IWD_FIRE
    } iwd_state_e;

    typedef enum logic {
        IWD_ACT_RESET,
        IWD_ACT_IRQ
    } iwd_action_e;
endpackage

// [verilog/iwd_tick_if.sv]
// Tick link between the prescaler and the watchdog core
`timescale 1ns/100ps
`default_nettype none
interface iwd_tick_if;
    logic clear;
    logic tick;
    modport core (output clear, input tick);
    modport presc (input clear, output tick);
endinterface
`default_nettype wire

// [verilog/iwd_prescaler.sv]
// One-second tick prescaler
`timescale 1ns/100ps
`default_nettype none
`include "iwd_map.svh"
module iwd_prescaler #(
    parameter int unsigned TICK_CYCLES = `IWD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tick link
    iwd_tick_if.presc tl
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } iwd_presc_s;

    iwd_presc_s st_r;
    iwd_presc_s st_nxt;

    // Clear realigns the second so a reload always gets full seconds
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (tl.clear || st_r.cnt == TICK_CYCLES - 1) begin
            st_nxt.cnt = 32'h0;
            st_nxt.tick = !tl.clear;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tl.tick = st_r.tick;
endmodule // iwd_prescaler
`default_nettype wire

// [verilog/iwd_watchdog.sv]
// Watchdog reached through one byte-wide I/O port
`timescale 1ns/100ps
`default_nettype none
`include "iwd_map.svh"
// What this block does
// - Write to port 443 loads and starts
// - Codes 01 to 3e mean seconds
// - Each rewrite restarts countdown from new value
// - Reading port 443 disables the watchdog
// - Expiry asserts CPU reset or interrupt
module iwd_watchdog #(
    parameter int unsigned TICK_CYCLES = `IWD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // I/O port access, one-cycle strobes
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Expiry action select, a strap level
    input wire logic act_irq_sel,
    // Status and actions
    output logic wd_running,
    output logic cpu_reset,
    output logic wd_irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        iwd_pkg::iwd_state_e state;
        iwd_pkg::iwd_action_e action;
        logic [5:0] secs;
        logic [7:0] rdata;
        logic [4:0] pulse;
        logic cpu_reset;
        logic irq;
        logic running;
    } iwd_core_s;

    iwd_core_s st_r;
    iwd_core_s st_nxt;

    logic wr_hit;
    logic rd_hit;
    logic load_ok;

    // ****************************************
    // Tick link
    // ****************************************
    iwd_tick_if tl ();

    // ****************************************
    // Decode helpers
    // ****************************************
    // Full compare, so no alias of the port can touch the timer
    function automatic logic hit(input logic [15:0] a);
        hit = (a == `IWD_PORT_ADDR);
    endfunction

    function automatic logic code_ok(input logic [7:0] d);
        code_ok = (d >= `IWD_CODE_MIN) && (d <= `IWD_CODE_MAX);
    endfunction

    function automatic iwd_pkg::iwd_action_e pick_action(input logic sel);
        if (sel) begin
            pick_action = iwd_pkg::IWD_ACT_IRQ;
        end else begin
            pick_action = iwd_pkg::IWD_ACT_RESET;
        end
    endfunction

    // ****************************************
    // Step helpers
    // ****************************************
    // Every field spelled out: the watchdog must wake disabled
    function automatic iwd_core_s reset_state();
        reset_state.state = iwd_pkg::IWD_IDLE;
        reset_state.action = iwd_pkg::IWD_ACT_RESET;
        reset_state.secs = 6'h0;
        reset_state.rdata = 8'h00;
        reset_state.pulse = 5'h0;
        reset_state.cpu_reset = 1'b0;
        reset_state.irq = 1'b0;
        reset_state.running = 1'b0;
    endfunction

    // Reset pulse runs down on its own, whatever the state does
    function automatic iwd_core_s pulse_step(input iwd_core_s s);
        pulse_step = s;
        pulse_step.cpu_reset = 1'b0;
        if (s.pulse != 5'h0) begin
            pulse_step.pulse = s.pulse - 5'h1;
            pulse_step.cpu_reset = 1'b1;
        end
    endfunction

    function automatic iwd_core_s count_step(
        input iwd_core_s s,
        input logic tick
    );
        count_step = s;
        unique case (s.state)
            iwd_pkg::IWD_IDLE: begin
            end
            iwd_pkg::IWD_RUN: begin
                if (tick) begin
                    if (s.secs == 6'h1) begin
                        count_step.state = iwd_pkg::IWD_FIRE;
                        count_step.secs = 6'h0;
                    end else begin
                        count_step.secs = s.secs - 6'h1;
                    end
                end
            end
            iwd_pkg::IWD_FIRE: begin
                // Timeout taken once; rearm only by a fresh write
                if (s.action == iwd_pkg::IWD_ACT_RESET) begin
                    count_step.pulse = 5'(`IWD_RST_PULSE_CYCLES);
                end else begin
                    count_step.irq = 1'b1;
                end
                count_step.state = iwd_pkg::IWD_IDLE;
            end
        endcase
    endfunction

    // Out-of-range codes never get here, so a bad write never arms it
    function automatic iwd_core_s arm(
        input iwd_core_s s,
        input logic [7:0] code,
        input logic sel
    );
        arm = s;
        arm.state = iwd_pkg::IWD_RUN;
        arm.secs = code[5:0];
        arm.action = pick_action(sel);
        arm.irq = 1'b0;
    endfunction

    // Read data show the seconds left at the moment of the read
    function automatic iwd_core_s disarm(
        input iwd_core_s s,
        input logic [5:0] left
    );
        disarm = s;
        disarm.rdata = {2'h0, left};
        disarm.state = iwd_pkg::IWD_IDLE;
        disarm.secs = 6'h0;
        disarm.irq = 1'b0;
    endfunction

    // ****************************************
    // Port decode and prescaler
    // ****************************************
    assign wr_hit = io_wr && hit(io_addr);
    assign rd_hit = io_rd && hit(io_addr);
    assign load_ok = wr_hit && code_ok(io_wdata);

    // A valid load realigns the second so every interval is whole
    assign tl.clear = load_ok;

    iwd_prescaler #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_presc (
        .clk(clk),
        .rst(rst),
        .tl(tl)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = pulse_step(st_r);
        st_nxt = count_step(st_nxt, tl.tick);
        if (load_ok) begin
            st_nxt = arm(st_nxt, io_wdata, act_irq_sel);
        end
        // Read wins over a same-cycle write: the disable is never lost
        if (rd_hit) begin
            st_nxt = disarm(st_nxt, st_r.secs);
        end
        st_nxt.running = (st_nxt.state == iwd_pkg::IWD_RUN);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= reset_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs, all straight from the state register
    // ****************************************
    assign io_rdata = st_r.rdata;
    assign wd_running = st_r.running;
    assign cpu_reset = st_r.cpu_reset;
    assign wd_irq = st_r.irq;
endmodule // iwd_watchdog
`default_nettype wire

// [verification/iwd_watchdog_sva.sv]
// Assertions on the port watchdog pins
`timescale 1ns/100ps
`default_nettype none
module iwd_chk (
    // Watched pins
    input wire logic clk, rst, io_wr, io_rd, wd_running, cpu_reset, wd_irq,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata
);
    // ****
    // Checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr, good;
    assign wr = io_wr && !io_rd && io_addr == 16'h0443;
    assign good = io_wdata inside {[8'h01:8'h3e]};
    a_idle_rst: assert property ($fell(rst) |-> !wd_running && !cpu_reset && !wd_irq)
        else $error("not idle after reset");
    a_wr_start: assert property (wr && good |=> wd_running)
        else $error("write did not start");
    a_bad_code: assert property (io_wr && !good && !wd_running |=> !wd_running)
        else $error("bad code started");
    a_rd_stop: assert property (io_rd && io_addr == 16'h0443 |=> !wd_running && !wd_irq)
        else $error("read did not stop");
    // A refresh must push any expiry well past the next few cycles
    a_refresh: assert property (wr && good |=> (!$rose(cpu_reset) && !$rose(wd_irq))[*8])
        else $error("expiry right after refresh");
    a_pulse_len: assert property ($rose(cpu_reset) |-> ##15 cpu_reset ##1 !cpu_reset)
        else $error("reset pulse length");
endmodule // iwd_chk
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench of the port watchdog
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int T = 20;
    logic clk = 0, rst = 1, io_wr = 0, io_rd = 0, act_irq_sel = 0;
    logic [15:0] io_addr = 16'h0443;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic wd_running, cpu_reset, wd_irq;
    int n_mismatch = 0, samples_checked = 0, cyc_n = 0;
    iwd_watchdog #(.TICK_CYCLES(T)) dut (.clk(clk), .rst(rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .act_irq_sel(act_irq_sel), .wd_running(wd_running), .cpu_reset(cpu_reset),
        .wd_irq(wd_irq));
    // ****
    // Clock, limit and tasks
    // ****
    always #50 clk = ~clk;
    // Longest wait is the 62 s code, about 1240 cycles
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_n(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic acc(logic w, logic [15:0] a, logic [7:0] d);
        io_wr = w;
        io_rd = !w;
        io_addr = a;
        io_wdata = d;
        wait_n(1);
        io_wr = 0;
        io_rd = 0;
        wait_n(1);
    endtask
    task automatic expire(logic [7:0] code);
        acc(1, 16'h0443, code);
        wait_n(code * T - 3);
        chk(wd_running, 1);
        for (int i = 0; i < 10 && !(cpu_reset | wd_irq); i++) wait_n(1);
        chk(act_irq_sel ? wd_irq : cpu_reset, 1);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        wait_n(16);
        rst = 0;
        chk(wd_running, 0);
        acc(1, 16'h0443, 8'h3f);
        chk(wd_running, 0);
        acc(1, 16'h0443, 8'h00);
        chk(wd_running, 0);
        acc(1, 16'h0442, 8'h05);
        chk(wd_running, 0);
        acc(1, 16'h0443, 8'h02);
        chk(wd_running, 1);
        acc(0, 16'h0443, 8'h00);
        chk(io_rdata, 8'h02);
        chk(wd_running, 0);
        expire(8'h01);
        wait_n(16);
        chk(cpu_reset, 0);
        act_irq_sel = 1;
        repeat (6) begin
            acc(1, 16'h0443, 8'h02);
            wait_n(14);
        end
        chk(wd_irq, 0);
        chk(wd_running, 1);
        expire(8'h3e);
        acc(0, 16'h0443, 8'h00);
        chk(wd_irq, 0);
        end_of_test();
    end
endmodule // tb
bind iwd_watchdog iwd_chk u_chk (.clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
    .wd_running(wd_running), .cpu_reset(cpu_reset), .wd_irq(wd_irq),
    .io_addr(io_addr), .io_wdata(io_wdata));
`default_nettype wire
